// ===== logic/watchdog_regs.sv
// watchdog control and status registers on APB with oscillator crossing
// Behaviour
// - upper control field sets closed window length
// - lower field 1 to B enables, sets time-out
// - in window mode lower field sets open window
// - lock set makes control writes ignored
// - software can only set the lock
// - only debug mode clears the lock
// - nonzero boot period sets lock automatically
// - lock write needs timed unlock first
// - control write raises busy until crossed
// - busy is read-only and freely readable
// - control reset value comes from boot fuse
// - restart starts new period; expiry resets system
// - restart in closed window resets system
`timescale 1ns/100ps
module watchdog_regs
  import watchdog_pkg::*;
#(
  parameter logic [2:0] UNLOCK_CYCLES = UNLOCK_WINDOW_CYCLES
)
(
  // clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  input wire logic [STRB_W-1:0] pstrb,
  output logic pready,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pslverr,
  // watchdog oscillator pin
  input wire logic wdt_osc,
  // boot and core side
  input wire control_type watchdog_boot_fuse,
  input wire logic boot_done,
  input wire logic debug_mode,
  input wire logic timed_change_unlock,
  input wire logic watchdog_restart_instruction,
  // reset request to the system
  output logic system_reset
);

  regs_type q;
  regs_type d;
  logic osc_tick;
  logic setup;
  logic complete;
  logic hit_control;
  logic hit_status;
  logic wr_ok;
  logic unlock_open;
  logic protected_access;
  logic ctrl_write;
  logic lock_write;
  logic boot_event;
  logic lock_set;
  logic expire;

  assign osc_tick = q.osc_sync & ~q.osc_prev;
  assign setup = psel & ~penable;
  assign complete = psel & penable & q.pready;
  assign hit_control = (paddr == CONTROL_ADDR);
  assign hit_status = (paddr == STATUS_ADDR);
  assign wr_ok = complete & pwrite & pstrb[0];
  assign unlock_open = (q.unlock_cnt != 3'h0);
  assign protected_access = wr_ok & (hit_control | hit_status) & unlock_open;
  // writes during busy are dropped, so a half-crossed value never mixes
  assign ctrl_write = wr_ok & hit_control & unlock_open & ~q.lock & ~q.busy;
  assign lock_write = wr_ok & hit_status & unlock_open & pwdata[LOCK_BIT];
  assign boot_event = ~q.boot_loaded & boot_done;
  assign lock_set = lock_write | (boot_event & (watchdog_boot_fuse.period != CODE_OFF));

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign system_reset = q.system_reset;

  always_comb
  begin
    d = q;
    d.osc_meta = wdt_osc;
    d.osc_sync = q.osc_meta;
    d.osc_prev = q.osc_sync;
    d.restart_fire = 1'b0;
    d.system_reset = expire;

    // apb: answer in the first access cycle, data latched at setup
    if (setup)
    begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      d.prdata = '0;
      if (hit_control)
        d.prdata[7:0] = q.control;
      else if (hit_status)
      begin
        d.prdata[LOCK_BIT] = q.lock;
        d.prdata[BUSY_BIT] = q.busy;
      end
      else
        d.pslverr = 1'b1;
    end
    else if (complete)
    begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end

    // timed unlock opens a short window consumed by one protected write
    if (timed_change_unlock)
      d.unlock_cnt = UNLOCK_CYCLES;
    else if (protected_access)
      d.unlock_cnt = 3'h0;
    else if (unlock_open)
      d.unlock_cnt = q.unlock_cnt - 3'h1;

    // fuse value is caught once, after reset release, when boot is done
    if (boot_event)
    begin
      d.control = watchdog_boot_fuse;
      d.active = watchdog_boot_fuse;
      d.boot_loaded = 1'b1;
    end
    else if (ctrl_write)
    begin
      d.control = control_type'(pwdata[7:0]);
      d.busy = 1'b1;
      d.sync_cnt = 2'h0;
    end
    else if (q.busy && osc_tick)
    begin
      if (q.sync_cnt == SYNC_TICKS - 2'h1)
      begin
        d.active = q.control;
        d.busy = 1'b0;
      end
      else
        d.sync_cnt = q.sync_cnt + 2'h1;
    end

    // set wins over the debug clear in the same cycle
    d.lock = (q.lock & ~debug_mode) | lock_set;

    // restart crosses on the second tick; a second one meanwhile is dropped
    if (q.restart_pending)
    begin
      if (osc_tick)
      begin
        if (q.restart_cnt == SYNC_TICKS - 2'h1)
        begin
          d.restart_pending = 1'b0;
          d.restart_fire = 1'b1;
        end
        else
          d.restart_cnt = q.restart_cnt + 2'h1;
      end
    end
    else if (watchdog_restart_instruction)
    begin
      d.restart_pending = 1'b1;
      d.restart_cnt = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.control <= CONTROL_RESET;
      q.active <= CONTROL_RESET;
      q.lock <= STATUS_RESET[LOCK_BIT];
      q.busy <= STATUS_RESET[BUSY_BIT];
      // prev starts high, but sync starts low: a pin already high at release still gives one tick
      q.osc_prev <= 1'b1;
    end
    else if (ce)
      q <= d;
  end

  watchdog_counter counter_inst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(osc_tick),
    .restart(q.restart_fire),
    .halt(debug_mode),
    .cfg(q.active),
    .expire(expire)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  chk_lock_blocks_ctrl: assert property (
    wr_ok && hit_control && q.lock && !boot_event |=> $stable(q.control) && !q.busy
      || $past(q.busy))
    else $error("control changed while locked");
  chk_lock_sticky: assert property (
    q.lock && !debug_mode |=> q.lock)
    else $error("lock cleared outside debug mode");
  chk_debug_clear: assert property (
    q.lock && debug_mode && !lock_set |=> !q.lock)
    else $error("debug mode did not clear lock");
  chk_boot_lock: assert property (
    boot_event && watchdog_boot_fuse.period != CODE_OFF |=> q.lock && q.boot_loaded)
    else $error("nonzero boot period left lock clear");
  chk_fuse_load: assert property (
    boot_event |=> q.control == $past(watchdog_boot_fuse)
      && q.active == $past(watchdog_boot_fuse))
    else $error("control did not take fuse value");
  chk_unlocked_write: assert property (
    wr_ok && hit_status && !unlock_open && !q.lock && !boot_event |=> !q.lock)
    else $error("lock set without timed unlock");
  chk_busy_raise: assert property (
    ctrl_write && !boot_event |=> q.busy && q.control == $past(pwdata[7:0]) ##1 q.busy)
    else $error("control write did not raise busy");
  chk_busy_fall: assert property (
    $fell(q.busy) |-> $past(osc_tick) && q.active == q.control)
    else $error("busy fell without oscillator crossing");
  chk_status_read: assert property (
    setup && hit_status |=> pready && !pslverr
      && prdata[BUSY_BIT] == $past(q.busy) && prdata[LOCK_BIT] == $past(q.lock))
    else $error("status read wrong");
  chk_ctrl_read: assert property (
    setup && hit_control
    |=> pready && !pslverr && prdata[7:0] == $past(q.control))
    else $error("control read wrong");
  chk_read_upper_zero: assert property (
    setup && hit_status
    |=> prdata[APB_DATA_W-1:8] == '0 && prdata[6:1] == '0)
    else $error("status read shows unused bits");
  chk_lock_write_set: assert property (
    lock_write
    |=> q.lock)
    else $error("protected lock write ignored");
  chk_zero_keeps_lock: assert property (
    wr_ok && hit_status && !pwdata[LOCK_BIT] && q.lock && !debug_mode
    |=> q.lock)
    else $error("zero write cleared the lock");
  chk_boot_no_lock: assert property (
    boot_event && watchdog_boot_fuse.period == CODE_OFF && !lock_write && !q.lock
    |=> !q.lock)
    else $error("zero boot period set the lock");
  chk_ctrl_needs_unlock: assert property (
    wr_ok && hit_control && !unlock_open && !boot_event
    |=> $stable(q.control) && !$rose(q.busy))
    else $error("control changed without timed unlock");
  chk_ctrl_sources: assert property (
    !ctrl_write && !boot_event
    |=> $stable(q.control))
    else $error("control changed with no write");
  chk_unlock_open: assert property (
    timed_change_unlock
    |=> q.unlock_cnt == UNLOCK_CYCLES)
    else $error("timed unlock did not open window");
  chk_unlock_consumed: assert property (
    protected_access && !timed_change_unlock
    |=> !unlock_open)
    else $error("unlock window survived a protected write");
  chk_busy_hold: assert property (
    q.busy && !osc_tick
    |=> q.busy)
    else $error("busy fell between oscillator ticks");
  chk_busy_source: assert property (
    !q.busy && !ctrl_write
    |=> !q.busy)
    else $error("busy rose with no control write");
  chk_busy_step: assert property (
    q.busy && osc_tick && !boot_event && q.sync_cnt != SYNC_TICKS - 2'h1
    |=> q.busy && q.sync_cnt == $past(q.sync_cnt) + 2'h1)
    else $error("crossing did not advance on a tick");
  chk_cross_copy: assert property (
    q.busy && osc_tick && !boot_event && q.sync_cnt == SYNC_TICKS - 2'h1
    |=> !q.busy && q.active == $past(q.control))
    else $error("crossing did not hand over control");
  chk_busy_read_only: assert property (
    wr_ok && hit_status && !q.busy
    |=> !q.busy)
    else $error("status write raised busy");
  chk_active_hold: assert property (
    !q.busy && !boot_event
    |=> $stable(q.active))
    else $error("watchdog settings changed outside a crossing");
  chk_restart_take: assert property (
    !q.restart_pending && watchdog_restart_instruction
    |=> q.restart_pending && q.restart_cnt == 2'h0)
    else $error("restart instruction not taken");
  chk_restart_hold: assert property (
    q.restart_pending && !osc_tick
    |=> q.restart_pending && $stable(q.restart_cnt) && !q.restart_fire)
    else $error("pending restart moved without a tick");
  chk_reset_follows: assert property (
    expire
    |=> system_reset)
    else $error("expiry gave no system reset");
  chk_reset_cause: assert property (
    !expire
    |=> !system_reset)
    else $error("system reset with no expiry");

  cov_locked_write: cover property (wr_ok && hit_control && q.lock);
  cov_ctrl_crossed: cover property (ctrl_write ##[1:1000] $fell(q.busy));
  cov_debug_clear: cover property (q.lock && debug_mode);

endmodule // watchdog_regs

// ===== shared/watchdog_pkg.sv
// package: watchdog register map, field layout, state types and timing constants
package watchdog_pkg;

  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned TICK_W = 14;
  localparam int unsigned WORD_SHIFT = 2;

  // register indices; a register's byte address is four times its index
  localparam logic [APB_ADDR_W-1:0] CONTROL_INDEX = 12'h000;
  localparam logic [APB_ADDR_W-1:0] STATUS_INDEX = 12'h001;
  localparam logic [APB_ADDR_W-1:0] CONTROL_ADDR = CONTROL_INDEX << WORD_SHIFT;
  localparam logic [APB_ADDR_W-1:0] STATUS_ADDR = STATUS_INDEX << WORD_SHIFT;

  // status field positions
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned BUSY_BIT = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // time-out codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam logic [3:0] CODE_ONE = 4'h1;

  // timing counts
  localparam logic [TICK_W-1:0] TIMEOUT_BASE_TICKS = 14'h0008;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } control_type;

  typedef enum logic [1:0] {
    PHASE_OFF = 2'b00,
    PHASE_FIRST = 2'b01,
    PHASE_CLOSED = 2'b10,
    PHASE_OPEN = 2'b11
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [TICK_W-1:0] count;
    logic expire;
  } counter_state_type;

  typedef struct packed {
    control_type control;
    control_type active;
    logic lock;
    logic busy;
    logic boot_loaded;
    logic [1:0] sync_cnt;
    logic restart_pending;
    logic [1:0] restart_cnt;
    logic restart_fire;
    logic [2:0] unlock_cnt;
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic pready;
    logic pslverr;
    logic [APB_DATA_W-1:0] prdata;
    logic system_reset;
  } regs_type;

  function automatic logic code_valid(input logic [3:0] code);
    code_valid = (code != CODE_OFF) && (code <= CODE_MAX);
  endfunction

  function automatic logic [TICK_W-1:0] timeout_ticks(input logic [3:0] code);
    timeout_ticks = TIMEOUT_BASE_TICKS << (code - CODE_ONE);
  endfunction

endpackage

// ===== logic/watchdog_counter.sv
// watchdog time-out counter stepped by oscillator ticks
`timescale 1ns/100ps
module watchdog_counter
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // oscillator domain events
  input wire logic tick,
  input wire logic restart,
  input wire logic halt,
  // settings already crossed into the oscillator domain
  input wire control_type cfg,
  // time-out result
  output logic expire
);

  counter_state_type q;
  counter_state_type d;
  logic running;
  logic window_on;
  logic [TICK_W-1:0] limit;
  logic [TICK_W-1:0] next_count;

  // reserved codes behave as off so a bad write cannot arm odd lengths
  assign running = code_valid(cfg.period);
  assign window_on = code_valid(cfg.window);
  assign limit = (q.phase == PHASE_CLOSED) ? timeout_ticks(cfg.window)
                                           : timeout_ticks(cfg.period);
  assign next_count = q.count + 14'h0001;
  assign expire = q.expire;

  always_comb
  begin
    d = q;
    d.expire = 1'b0;
    if (halt)
    begin
      // after a halt the first period is a plain time-out, closed window skipped
      d.count = '0;
      d.phase = running ? PHASE_FIRST : PHASE_OFF;
    end
    else if (!running)
    begin
      d.count = '0;
      d.phase = PHASE_OFF;
    end
    else if (restart)
    begin
      d.count = '0;
      case (q.phase)
        PHASE_CLOSED:
        begin
          d.expire = 1'b1;
          d.phase = PHASE_FIRST;
        end
        default:
          d.phase = window_on ? PHASE_CLOSED : PHASE_FIRST;
      endcase
    end
    else if (!window_on && (q.phase == PHASE_CLOSED || q.phase == PHASE_OPEN))
    begin
      d.count = '0;
      d.phase = PHASE_FIRST;
    end
    else if (q.phase == PHASE_OFF)
    begin
      d.count = '0;
      d.phase = PHASE_FIRST;
    end
    else if (tick)
    begin
      if (next_count >= limit)
      begin
        d.count = '0;
        if (q.phase == PHASE_CLOSED)
          d.phase = PHASE_OPEN;
        else
        begin
          d.expire = 1'b1;
          d.phase = PHASE_FIRST;
        end
      end
      else
        d.count = next_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  chk_closed_restart: assert property (
    restart && !halt && running && q.phase == PHASE_CLOSED |=> expire)
    else $error("restart in closed window gave no reset");
  chk_restart_rearm: assert property (
    restart && !halt && running && q.phase != PHASE_CLOSED
    |=> q.count == '0 && !expire
        && q.phase == ($past(window_on) ? PHASE_CLOSED : PHASE_FIRST))
    else $error("restart did not start a new period");
  chk_expire_limit: assert property (
    tick && !restart && !halt && running && q.phase == PHASE_FIRST
    && next_count == timeout_ticks(cfg.period) |=> expire)
    else $error("time-out not at coded tick count");
  chk_open_follow: assert property (
    tick && !restart && !halt && running && window_on && q.phase == PHASE_CLOSED
    && next_count == timeout_ticks(cfg.window) |=> q.phase == PHASE_OPEN && !expire)
    else $error("open window did not follow closed window");
  chk_off_silent: assert property (
    !running |=> q.phase == PHASE_OFF && !expire)
    else $error("disabled watchdog still counting");

  cov_expire: cover property (expire);
  cov_open_phase: cover property (q.phase == PHASE_OPEN);

endmodule // watchdog_counter

// ===== test/tb_watchdog_regs.sv
// self-checking bench for the watchdog control and status registers
`timescale 1ns/100ps
module tb_watchdog_regs
  import watchdog_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] exp;
    logic [7:0] mask;
    logic err;
  } note_type;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [APB_DATA_W-1:0] pwdata = '0;
  logic pready;
  logic [APB_DATA_W-1:0] prdata;
  logic pslverr;
  logic osc = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  control_type fuse = '0;
  logic boot = 1'b0;
  logic debug = 1'b0;
  logic tcu = 1'b0;
  logic wri = 1'b0;
  logic sreset;
  note_type notes[$];
  note_type n;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  watchdog_regs u_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wdt_osc(osc), .watchdog_boot_fuse(fuse),
    .boot_done(boot), .debug_mode(debug), .timed_change_unlock(tcu),
    .watchdog_restart_instruction(wri), .system_reset(sreset)
  );

  always #2 pclk = ~pclk;

  // free-running oscillator, one tick every 16 pclk
  always @(posedge pclk)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    if (osc_cnt == 3'h7)
      osc <= ~osc;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  task automatic test_done;
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // results are judged at the completion edge against the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      n = notes.pop_front();
      checks++;
      if (((prdata[7:0] & n.mask) !== (n.exp & n.mask)) || (pslverr !== n.err))
      begin
        n_fail++;
        $display("BAD t=%0t exp=%h got=%h", $time, {n.err, n.exp}, {pslverr, prdata[7:0]});
      end
    end
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic [7:0] m, input logic er,
                      input logic u, output logic [7:0] rd);
    @(posedge pclk);
    tcu <= u;
    @(posedge pclk);
    tcu <= 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    notes.push_back('{e, m, er});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic u);
    logic [7:0] rd;
    xfer(1'b1, a, d, 8'h00, 8'h00, 1'b0, u, rd);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] rd;
    xfer(1'b0, a, 8'h00, e, m, 1'b0, 1'b0, rd);
  endtask

  // software must not write control again until the crossing is done
  task automatic wait_idle;
    logic [7:0] rd;
    rd = 8'h01;
    for (int i = 0; i < 40 && rd[BUSY_BIT] !== 1'b0; i++)
      xfer(1'b0, STATUS_ADDR, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, rd);
    checks++;
    if (rd[BUSY_BIT] !== 1'b0)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, 8'h00, rd);
    end
  endtask

  task automatic setc(input logic [7:0] v);
    wr(CONTROL_ADDR, v, 1'b1);
    wait_idle;
  endtask

  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0)
      wri <= 1'b1;
    else
      debug <= 1'b1;
    repeat (2) @(posedge pclk);
    wri <= 1'b0;
    debug <= 1'b0;
  endtask

  // expects a reset pulse after lo and before hi cycles; want of 0 means none before hi
  task automatic watch(input int lo, input int hi, input logic want);
    int i;
    for (i = 0; i < hi; i++)
    begin
      @(posedge pclk);
      if (sreset === 1'b1)
        break;
    end
    checks++;
    if (want ? (i < lo || i >= hi) : (i < hi))
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, lo, i);
    end
  endtask

  initial
  begin
    logic [7:0] v;
    logic [7:0] rd;
    v = 8'h00;
    v[0] = $urandom(649);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CONTROL_ADDR, CONTROL_RESET, 8'hFF);
    rdc(STATUS_ADDR, STATUS_RESET, 8'hFF);
    fuse <= 8'h30;
    boot <= 1'b1;
    @(posedge pclk);
    rdc(CONTROL_ADDR, 8'h30, 8'hFF);
    rdc(STATUS_ADDR, 8'h00, 8'h80);
    wr(CONTROL_ADDR, 8'h12, 1'b0);
    rdc(CONTROL_ADDR, 8'h30, 8'hFF);
    wr(CONTROL_ADDR, 8'h12, 1'b1);
    rdc(STATUS_ADDR, 8'h01, 8'h01);
    wait_idle;
    rdc(CONTROL_ADDR, 8'h12, 8'hFF);
    wr(STATUS_ADDR, 8'h81, 1'b0);
    rdc(STATUS_ADDR, 8'h00, 8'hFF);
    wr(STATUS_ADDR, 8'h81, 1'b1);
    rdc(STATUS_ADDR, 8'h80, 8'hFF);
    wr(CONTROL_ADDR, 8'h00, 1'b1);
    rdc(CONTROL_ADDR, 8'h12, 8'hFF);
    wr(STATUS_ADDR, 8'h00, 1'b1);
    rdc(STATUS_ADDR, 8'h80, 8'hFF);
    pulse(1);
    rdc(STATUS_ADDR, 8'h00, 8'hFF);
    repeat (3)
    begin
      v[7:4] = 4'($urandom % 16);
      v[3:0] = 4'($urandom % 16);
      setc(v);
      rdc(CONTROL_ADDR, v, 8'hFF);
    end
    xfer(1'b0, 12'h008, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, rd);
    // normal mode: a second restart must push the expiry out again
    setc(8'h01);
    // a halt clears the count left over from the random settings
    pulse(1);
    pulse(0);
    watch(0, 96, 1'b0);
    pulse(0);
    watch(128, 224, 1'b1);
    // window mode: a restart inside the closed window is punished
    setc(8'h11);
    pulse(0);
    watch(0, 64, 1'b0);
    pulse(0);
    watch(8, 120, 1'b1);
    // a restart in the open window is legal and starts a new closed window
    pulse(0);
    watch(0, 192, 1'b0);
    pulse(0);
    watch(224, 480, 1'b1);
    // mid-run reset with an enabling fuse locks at boot
    presetn <= 1'b0;
    boot <= 1'b0;
    fuse <= 8'h05;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    boot <= 1'b1;
    @(posedge pclk);
    rdc(CONTROL_ADDR, 8'h05, 8'hFF);
    rdc(STATUS_ADDR, 8'h80, 8'h80);
    wr(CONTROL_ADDR, 8'h00, 1'b1);
    rdc(CONTROL_ADDR, 8'h05, 8'hFF);
    pulse(1);
    rdc(STATUS_ADDR, 8'h00, 8'h80);
    test_done;
  end
endmodule // tb_watchdog_regs
